/* core/pfsm_top.sv */
// per-pin function selection and port 1 peripheral arbitration
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pfsm_params.svh"

module pfsm_top
	import pfsm_pkg::*;
#(
	parameter int P0_PINS = `PFSM_PORT0_PINS,
	parameter int P1_PINS = `PFSM_PORT1_PINS,
	parameter int P2_PINS = `PFSM_PORT2_PINS
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_b,
	// register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_write,
	input  wire logic                reg_read,
	output logic      [7:0]          reg_rdata,
	// overrides from neighbouring units
	input  wire logic [P0_PINS-1:0]  converter_input_config,
	input  wire logic                debug_active,
	input  wire logic                audio_enable,
	input  wire logic [P0_PINS-1:0]  audio_port0_claim,
	input  wire logic [P1_PINS-1:0]  audio_port1_claim,
	input  wire logic [P1_PINS-1:0]  audio_out,
	input  wire logic [P1_PINS-1:0]  audio_oe,
	input  wire logic [1:0]          debug_out,
	input  wire logic [1:0]          debug_oe,
	// general I/O drive per port
	input  wire logic [P0_PINS-1:0]  gpio0_out,
	input  wire logic [P0_PINS-1:0]  gpio0_oe,
	input  wire logic [P1_PINS-1:0]  gpio1_out,
	input  wire logic [P1_PINS-1:0]  gpio1_oe,
	input  wire logic [P2_PINS-1:0]  gpio2_out,
	input  wire logic [P2_PINS-1:0]  gpio2_oe,
	// peripheral drive for ports 0 and 2
	input  wire logic [P0_PINS-1:0]  periph0_out,
	input  wire logic [P0_PINS-1:0]  periph0_oe,
	input  wire logic [P2_PINS-1:0]  periph2_out,
	input  wire logic [P2_PINS-1:0]  periph2_oe,
	// port 1 contenders, index 0 serial0, 1 serial1, 2 timer1, 3 timer3, 4 timer4
	input  wire logic [4:0][P1_PINS-1:0] unit_claim,
	input  wire logic [4:0][P1_PINS-1:0] unit_out,
	input  wire logic [4:0][P1_PINS-1:0] unit_oe,
	// pin drive
	output logic      [P0_PINS-1:0]  port0_out,
	output logic      [P0_PINS-1:0]  port0_oe,
	output logic      [P0_PINS-1:0]  port0_analog,
	output logic      [P1_PINS-1:0]  port1_out,
	output logic      [P1_PINS-1:0]  port1_oe,
	output logic      [P2_PINS-1:0]  port2_out,
	output logic      [P2_PINS-1:0]  port2_oe,
	// port 1 owners, three bits per pin
	output logic [P1_PINS-1:0][2:0]  port1_owner
);

	pfsm_cfg_if cfg ();

	////////////////////////////////////////////////////////////////////////////////
	// register file
	pfsm_regs u_regs (
		.clk       (clk),
		.rst_b     (rst_b),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_write (reg_write),
		.reg_read  (reg_read),
		.reg_rdata (reg_rdata),
		.cfg       (cfg)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pairwise precedence between two port 1 contenders
	function automatic logic beats(input logic [2:0] a, input logic [2:0] b,
		input logic [6:0] pri);
		logic win;
		win = (a < b);
		if (a == 3'(PFSM_CAND_SERIAL0) && b == 3'(PFSM_CAND_SERIAL1))
			win = !pri[`PFSM_SERIAL_PAIR_BIT];
		if (a == 3'(PFSM_CAND_SERIAL1) && b == 3'(PFSM_CAND_SERIAL0))
			win = pri[`PFSM_SERIAL_PAIR_BIT];
		if (a == 3'(PFSM_CAND_SERIAL1) && b == 3'(PFSM_CAND_TIMER3))
			win = !pri[`PFSM_SERIAL1_TIMER3_BIT];
		if (a == 3'(PFSM_CAND_TIMER3) && b == 3'(PFSM_CAND_SERIAL1))
			win = pri[`PFSM_SERIAL1_TIMER3_BIT];
		if (a == 3'(PFSM_CAND_TIMER1) && b == 3'(PFSM_CAND_TIMER4))
			win = !pri[`PFSM_TIMER1_TIMER4_BIT];
		if (a == 3'(PFSM_CAND_TIMER4) && b == 3'(PFSM_CAND_TIMER1))
			win = pri[`PFSM_TIMER1_TIMER4_BIT];
		if (a == 3'(PFSM_CAND_SERIAL0) && b == 3'(PFSM_CAND_TIMER1))
			win = !pri[`PFSM_SERIAL0_TIMER1_BIT];
		if (a == 3'(PFSM_CAND_TIMER1) && b == 3'(PFSM_CAND_SERIAL0))
			win = pri[`PFSM_SERIAL0_TIMER1_BIT];
		return win;
	endfunction

	// first claimant that beats every other claimant; lowest claimant if none does
	function automatic logic [2:0] pick(input logic [4:0] claim, input logic [6:0] pri);
		logic [2:0] sel;
		logic       found;
		logic       all_win;
		sel   = 3'd0;
		found = 1'b0;
		for (int i = 4; i >= 0; i--) begin
			if (claim[i])
				sel = 3'(i);
		end
		for (int i = 0; i < 5; i++) begin
			all_win = claim[i];
			for (int j = 0; j < 5; j++) begin
				if (j != i && claim[j] && !beats(3'(i), 3'(j), pri))
					all_win = 1'b0;
			end
			if (all_win && !found) begin
				sel   = 3'(i);
				found = 1'b1;
			end
		end
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// port 1 contender per pin
	logic [P1_PINS-1:0][2:0] winner;
	logic [P1_PINS-1:0]      any_claim;

	genvar g;
	generate
		for (g = 0; g < P1_PINS; g++) begin : g_p1
			assign any_claim[g] = |{unit_claim[4][g], unit_claim[3][g], unit_claim[2][g],
				unit_claim[1][g], unit_claim[0][g]};
			assign winner[g] = pick({unit_claim[4][g], unit_claim[3][g], unit_claim[2][g],
				unit_claim[1][g], unit_claim[0][g]}, cfg.port2_select_and_priority);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// next pin drive
	logic [P0_PINS-1:0]      next_port0_out;
	logic [P0_PINS-1:0]      next_port0_oe;
	logic [P0_PINS-1:0]      next_port0_analog;
	logic [P1_PINS-1:0]      next_port1_out;
	logic [P1_PINS-1:0]      next_port1_oe;
	logic [P2_PINS-1:0]      next_port2_out;
	logic [P2_PINS-1:0]      next_port2_oe;
	logic [P1_PINS-1:0][2:0] next_port1_owner;
	logic [P2_PINS-1:0]      p2_sel;

	always_comb begin
		// port 2 select bits spread onto pins 4, 3 and 0
		p2_sel    = '0;
		p2_sel[0] = cfg.port2_select_and_priority[`PFSM_PORT2_PIN0_BIT];
		p2_sel[3] = cfg.port2_select_and_priority[`PFSM_PORT2_PIN3_BIT];
		p2_sel[4] = cfg.port2_select_and_priority[`PFSM_PORT2_PIN4_BIT];
		// port 0: converter, then audio, then select bit
		for (int i = 0; i < P0_PINS; i++) begin
			next_port0_analog[i] = converter_input_config[i];
			if (converter_input_config[i]) begin
				next_port0_out[i] = 1'b0;
				next_port0_oe[i]  = 1'b0;
			end else if (audio_enable && audio_port0_claim[i]) begin
				next_port0_out[i] = audio_out[i];
				next_port0_oe[i]  = audio_oe[i];
			end else if (cfg.port0_function_select[i]) begin
				next_port0_out[i] = periph0_out[i];
				next_port0_oe[i]  = periph0_oe[i];
			end else begin
				next_port0_out[i] = gpio0_out[i];
				next_port0_oe[i]  = gpio0_oe[i];
			end
		end
		// port 1: audio, then arbitrated peripheral, then general I/O
		for (int i = 0; i < P1_PINS; i++) begin
			if (audio_enable && audio_port1_claim[i]) begin
				next_port1_out[i]   = audio_out[i];
				next_port1_oe[i]    = audio_oe[i];
				next_port1_owner[i] = 3'(PFSM_OWN_AUDIO);
			end else if (cfg.port1_function_select[i] && any_claim[i]) begin
				next_port1_out[i]   = unit_out[winner[i]][i];
				next_port1_oe[i]    = unit_oe[winner[i]][i];
				next_port1_owner[i] = 3'(winner[i] + 3'd1);
			end else begin
				next_port1_out[i]   = gpio1_out[i];
				next_port1_oe[i]    = gpio1_oe[i];
				next_port1_owner[i] = 3'(PFSM_OWN_GPIO);
			end
		end
		// port 2: debug on pins 1 and 2 beats everything
		for (int i = 0; i < P2_PINS; i++) begin
			if (p2_sel[i]) begin
				next_port2_out[i] = periph2_out[i];
				next_port2_oe[i]  = periph2_oe[i];
			end else begin
				next_port2_out[i] = gpio2_out[i];
				next_port2_oe[i]  = gpio2_oe[i];
			end
		end
		if (debug_active) begin
			next_port2_out[2:1] = debug_out;
			next_port2_oe[2:1]  = debug_oe;
		end
	end

	// pin drive registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port0_out    <= '0;
			port0_oe     <= '0;
			port0_analog <= '0;
			port1_out    <= '0;
			port1_oe     <= '0;
			port2_out    <= '0;
			port2_oe     <= '0;
			port1_owner  <= '0;
		end else begin
			port0_out    <= next_port0_out;
			port0_oe     <= next_port0_oe;
			port0_analog <= next_port0_analog;
			port1_out    <= next_port1_out;
			port1_oe     <= next_port1_oe;
			port2_out    <= next_port2_out;
			port2_oe     <= next_port2_oe;
			port1_owner  <= next_port1_owner;
		end
	end

endmodule

`default_nettype wire

/* shared/pfsm_params.svh */
// offsets, field positions and reset values of the port function select block
`ifndef PFSM_PARAMS_SVH
`define PFSM_PARAMS_SVH

// register offsets on the register port
`define PFSM_PORT0_SELECT_ADDR 8'hf3
`define PFSM_PORT1_SELECT_ADDR 8'hf4
`define PFSM_PORT2_SELECT_ADDR 8'hf5

// reset values
`define PFSM_PORT0_SELECT_RESET 8'h00
`define PFSM_PORT1_SELECT_RESET 8'h00
`define PFSM_PORT2_SELECT_RESET 7'h00

// field positions in the port 2 select and priority register
`define PFSM_SERIAL_PAIR_BIT     6
`define PFSM_SERIAL1_TIMER3_BIT  5
`define PFSM_TIMER1_TIMER4_BIT   4
`define PFSM_SERIAL0_TIMER1_BIT  3
`define PFSM_PORT2_PIN4_BIT      2
`define PFSM_PORT2_PIN3_BIT      1
`define PFSM_PORT2_PIN0_BIT      0
`define PFSM_PORT2_USED_MASK     8'h7f

// port widths
`define PFSM_PORT0_PINS 8
`define PFSM_PORT1_PINS 8
`define PFSM_PORT2_PINS 5

`endif

/* shared/pfsm_pkg.sv */
// types of the port function select block
package pfsm_pkg;

	// who drives a port 1 pin
	typedef enum logic [2:0] {
		PFSM_OWN_GPIO,
		PFSM_OWN_SERIAL0,
		PFSM_OWN_SERIAL1,
		PFSM_OWN_TIMER1,
		PFSM_OWN_TIMER3,
		PFSM_OWN_TIMER4,
		PFSM_OWN_AUDIO
	} pfsm_owner_type;

	// port 1 peripheral contenders, in index order
	typedef enum logic [2:0] {
		PFSM_CAND_SERIAL0,
		PFSM_CAND_SERIAL1,
		PFSM_CAND_TIMER1,
		PFSM_CAND_TIMER3,
		PFSM_CAND_TIMER4
	} pfsm_cand_type;

endpackage

/* shared/pfsm_cfg_if.sv */
// configuration carried from the select registers to the pin mux
`timescale 1ns/1ps
`default_nettype none

interface pfsm_cfg_if;
	logic [7:0] port0_function_select;
	logic [7:0] port1_function_select;
	logic [6:0] port2_select_and_priority;

	modport regs (output port0_function_select, port1_function_select,
		port2_select_and_priority);
	modport mux (input port0_function_select, port1_function_select,
		port2_select_and_priority);
endinterface

`default_nettype wire

/* core/pfsm_regs.sv */
// select and priority registers behind the plain register port
`timescale 1ns/1ps
`default_nettype none
`include "pfsm_params.svh"

module pfsm_regs
	import pfsm_pkg::*;
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_b,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	// configuration toward the mux
	pfsm_cfg_if.regs        cfg
);

	logic [7:0] port0_function_select;
	logic [7:0] port1_function_select;
	logic [6:0] port2_select_and_priority;
	logic [7:0] next_port0_function_select;
	logic [7:0] next_port1_function_select;
	logic [6:0] next_port2_select_and_priority;
	logic [7:0] next_reg_rdata;

	// write decode and registered read data
	always_comb begin
		next_port0_function_select     = port0_function_select;
		next_port1_function_select     = port1_function_select;
		next_port2_select_and_priority = port2_select_and_priority;
		next_reg_rdata                 = 8'h00;
		if (reg_write) begin
			case (reg_addr)
				`PFSM_PORT0_SELECT_ADDR: next_port0_function_select = reg_wdata;
				`PFSM_PORT1_SELECT_ADDR: next_port1_function_select = reg_wdata;
				`PFSM_PORT2_SELECT_ADDR: next_port2_select_and_priority = reg_wdata[6:0];
				default: ;
			endcase
		end
		if (reg_read) begin
			case (reg_addr)
				`PFSM_PORT0_SELECT_ADDR: next_reg_rdata = port0_function_select;
				`PFSM_PORT1_SELECT_ADDR: next_reg_rdata = port1_function_select;
				`PFSM_PORT2_SELECT_ADDR: next_reg_rdata = {1'b0, port2_select_and_priority};
				default:                 next_reg_rdata = 8'h00;
			endcase
		end
	end

	// register state, all cleared by reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port0_function_select     <= `PFSM_PORT0_SELECT_RESET;
			port1_function_select     <= `PFSM_PORT1_SELECT_RESET;
			port2_select_and_priority <= `PFSM_PORT2_SELECT_RESET;
			reg_rdata                 <= 8'h00;
		end else begin
			port0_function_select     <= next_port0_function_select;
			port1_function_select     <= next_port1_function_select;
			port2_select_and_priority <= next_port2_select_and_priority;
			reg_rdata                 <= next_reg_rdata;
		end
	end

	assign cfg.port0_function_select     = port0_function_select;
	assign cfg.port1_function_select     = port1_function_select;
	assign cfg.port2_select_and_priority = port2_select_and_priority;

endmodule

`default_nettype wire

/* tb/pfsm_far_model.sv */
// fixed drive of general I/O, peripherals, audio and debug units
`timescale 1ns/1ps
`default_nettype none

module pfsm_far_model (
	// general I/O drive
	output logic [7:0]      gpio0_out,
	output logic [7:0]      gpio0_oe,
	output logic [7:0]      gpio1_out,
	output logic [7:0]      gpio1_oe,
	output logic [4:0]      gpio2_out,
	output logic [4:0]      gpio2_oe,
	// peripheral drive
	output logic [7:0]      periph0_out,
	output logic [7:0]      periph0_oe,
	output logic [4:0]      periph2_out,
	output logic [4:0]      periph2_oe,
	output logic [4:0][7:0] unit_out,
	output logic [4:0][7:0] unit_oe,
	// audio and debug drive
	output logic [7:0]      audio_out,
	output logic [7:0]      audio_oe,
	output logic [1:0]      debug_out,
	output logic [1:0]      debug_oe
);
	// distinct patterns so each source is told apart at the pins
	assign gpio0_out   = 8'h3c;
	assign gpio0_oe    = 8'h96;
	assign gpio1_out   = 8'h5a;
	assign gpio1_oe    = 8'hff;
	assign gpio2_out   = 5'h15;
	assign gpio2_oe    = 5'h0b;
	assign periph0_out = 8'hc3;
	assign periph0_oe  = 8'h69;
	assign periph2_out = 5'h0a;
	assign periph2_oe  = 5'h1c;
	// pin 0 levels differ within every contending pair
	assign unit_out    = {8'hc5, 8'h93, 8'h6a, 8'h2c, 8'hb7};
	assign unit_oe     = ~unit_out;
	assign audio_out   = 8'he1;
	assign audio_oe    = 8'h0f;
	assign debug_out   = 2'b01;
	assign debug_oe    = 2'b10;
endmodule

`default_nettype wire

/* tb/pfsm_top_monitor.sv */
// concurrent checks on the pin mux ports
`timescale 1ns/1ps
`default_nettype none

module pfsm_checker
	import pfsm_pkg::*;
#(
	parameter int P0_PINS = 8,
	parameter int P1_PINS = 8,
	parameter int P2_PINS = 5
) (
	// clock, reset and register port
	input wire logic                     clk,
	input wire logic                     rst_b,
	input wire logic [7:0]               reg_addr,
	input wire logic [7:0]               reg_wdata,
	input wire logic                     reg_write,
	input wire logic                     reg_read,
	input wire logic [7:0]               reg_rdata,
	// overrides and sources
	input wire logic [P0_PINS-1:0]       converter_input_config,
	input wire logic                     debug_active,
	input wire logic                     audio_enable,
	input wire logic [P1_PINS-1:0]       audio_port1_claim,
	input wire logic [1:0]               debug_out,
	input wire logic [1:0]               debug_oe,
	input wire logic [P1_PINS-1:0]       gpio1_out,
	input wire logic [P2_PINS-1:0]       periph2_out,
	input wire logic [4:0][P1_PINS-1:0]  unit_claim,
	input wire logic [4:0][P1_PINS-1:0]  unit_out,
	// pin drive
	input wire logic [P0_PINS-1:0]       port0_oe,
	input wire logic [P0_PINS-1:0]       port0_analog,
	input wire logic [P1_PINS-1:0]       port1_out,
	input wire logic [P2_PINS-1:0]       port2_out,
	input wire logic [P2_PINS-1:0]       port2_oe,
	input wire logic [P1_PINS-1:0][2:0]  port1_owner
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////
	// register behaviour
	a_p0_readback: assert property (reg_write && reg_addr == 8'hf3 ##1 !reg_write
		##1 reg_read && reg_addr == 8'hf3 |=> reg_rdata == $past(reg_wdata, 3))
		else $error("port 0 select readback wrong");
	a_p2_top_zero: assert property ($past(reg_read) && $past(reg_addr) == 8'hf5 |-> !reg_rdata[7])
		else $error("port 2 register top bit set");
	a_p2_pin0: assert property ($past(reg_write) && $past(reg_addr) == 8'hf5
		&& $past(reg_wdata[0]) |=> port2_out[0] == $past(periph2_out[0]))
		else $error("port 2 pin 0 not peripheral");

	////////////////////////////////////////////////////////////////////
	// pin ownership
	a_analog_force: assert property ($past(rst_b) |-> port0_analog == $past(converter_input_config)
		&& (port0_oe & $past(converter_input_config)) == '0)
		else $error("converter pin not analog");
	a_debug_owns: assert property (debug_active |=> port2_oe[2:1] == $past(debug_oe)
		&& port2_out[2:1] == $past(debug_out))
		else $error("debug pins not owned by debug");
	a_audio_wins: assert property (audio_enable && audio_port1_claim[0] |=> port1_owner[0] == PFSM_OWN_AUDIO)
		else $error("audio not owner of port 1 pin 0");
	a_gpio_drive: assert property ($past(rst_b) && port1_owner[0] == PFSM_OWN_GPIO
		|-> port1_out[0] == $past(gpio1_out[0]))
		else $error("port 1 pin 0 gpio drive wrong");
	a_serial_claim: assert property (port1_owner[0] == PFSM_OWN_SERIAL0
		|-> $past(unit_claim[0][0]) && port1_out[0] == $past(unit_out[0][0]))
		else $error("serial zero owner without claim");

	// main scenarios
	c_audio: cover property (port1_owner[0] == PFSM_OWN_AUDIO);
	c_timer4: cover property (port1_owner[0] == PFSM_OWN_TIMER4);
	c_analog: cover property (port0_analog != '0);
endmodule

bind pfsm_top pfsm_checker #(.P0_PINS(P0_PINS), .P1_PINS(P1_PINS), .P2_PINS(P2_PINS)) u_chk (
	.clk, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
	.converter_input_config, .debug_active, .audio_enable, .audio_port1_claim,
	.debug_out, .debug_oe, .gpio1_out, .periph2_out, .unit_claim, .unit_out,
	.port0_oe, .port0_analog, .port1_out, .port2_out, .port2_oe, .port1_owner);

`default_nettype wire

/* tb/pfsm_top_tb.sv */
// self-checking bench of the port function select block
`timescale 1ns/1ps
`default_nettype none

module pfsm_top_tb
	import pfsm_pkg::*;
;
	logic clk = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic debug_active = 1'b0, audio_enable = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, converter_input_config = 8'h00;
	logic [7:0] audio_port0_claim = 8'h00, audio_port1_claim = 8'h00;
	logic [4:0][7:0] unit_claim = '0;
	logic [7:0] reg_rdata, audio_out, audio_oe, gpio0_out, gpio0_oe, gpio1_out, gpio1_oe;
	logic [7:0] periph0_out, periph0_oe, port0_out, port0_oe, port0_analog, port1_out, port1_oe;
	logic [4:0] gpio2_out, gpio2_oe, periph2_out, periph2_oe, port2_out, port2_oe;
	logic [1:0] debug_out, debug_oe;
	logic [4:0][7:0] unit_out, unit_oe;
	logic [7:0][2:0] port1_owner;
	int num_errors = 0, num_checks = 0, cycles = 0;

	pfsm_far_model far (.gpio0_out, .gpio0_oe, .gpio1_out, .gpio1_oe, .gpio2_out, .gpio2_oe,
		.periph0_out, .periph0_oe, .periph2_out, .periph2_oe, .unit_out, .unit_oe,
		.audio_out, .audio_oe, .debug_out, .debug_oe);
	pfsm_top dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.converter_input_config, .debug_active, .audio_enable, .audio_port0_claim,
		.audio_port1_claim, .audio_out, .audio_oe, .debug_out, .debug_oe, .gpio0_out,
		.gpio0_oe, .gpio1_out, .gpio1_oe, .gpio2_out, .gpio2_oe, .periph0_out, .periph0_oe,
		.periph2_out, .periph2_oe, .unit_claim, .unit_out, .unit_oe, .port0_out, .port0_oe,
		.port0_analog, .port1_out, .port1_oe, .port2_out, .port2_oe, .port1_owner);

	////////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, exp);
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_regs;
		rd(8'hf3, 8'h00);
		rd(8'hf4, 8'h00);
		rd(8'hf5, 8'h00);
		rd(8'hf6, 8'h00);
		wr(8'hf3, 8'ha5);
		rd(8'hf3, 8'ha5);
		wr(8'hf4, 8'h5a);
		rd(8'hf4, 8'h5a);
		wr(8'hf5, 8'hff);
		rd(8'hf5, 8'h7f);
	endtask
	task automatic t_port0;
		logic [7:0] exp_out;
		logic [7:0] exp_oe;
		wr(8'hf3, 8'h0f);
		converter_input_config <= 8'h81;
		settle();
		// low nibble peripheral, high nibble general I/O, pins 7 and 0 analog
		exp_out = ((periph0_out & 8'h0f) | (gpio0_out & 8'hf0)) & 8'h7e;
		exp_oe  = ((periph0_oe & 8'h0f) | (gpio0_oe & 8'hf0)) & 8'h7e;
		chk("port0_out", port0_out, exp_out);
		chk("port0_oe", port0_oe, exp_oe);
		chk("port0_analog", port0_analog, 8'h81);
	endtask
	task automatic t_priority;
		int a_idx[4] = '{0, 1, 2, 0};
		int b_idx[4] = '{1, 3, 4, 2};
		int pos[4] = '{6, 5, 4, 3};
		int w;
		wr(8'hf4, 8'h01);
		for (int i = 0; i < 4; i++) begin
			for (int v = 0; v < 2; v++) begin
				@(posedge clk);
				unit_claim <= (40'h1 << (8 * a_idx[i])) | (40'h1 << (8 * b_idx[i]));
				wr(8'hf5, 8'(v << pos[i]));
				settle();
				w = v ? b_idx[i] : a_idx[i];
				chk("port1_owner", 8'(port1_owner[0]), 8'(w + 1));
				chk("port1_out", 8'(port1_out[0]), 8'(unit_out[w][0]));
				chk("port1_oe", 8'(port1_oe[0]), 8'(unit_oe[w][0]));
			end
		end
		wr(8'hf4, 8'h00);
		settle();
		chk("port1_owner", 8'(port1_owner[0]), 8'(PFSM_OWN_GPIO));
	endtask
	task automatic t_audio;
		@(posedge clk);
		audio_enable <= 1'b1;
		audio_port1_claim <= 8'h01;
		audio_port0_claim <= 8'h02;
		settle();
		chk("port1_owner", 8'(port1_owner[0]), 8'(PFSM_OWN_AUDIO));
		chk("port1_out", 8'(port1_out[0]), 8'(audio_out[0]));
		chk("port1_oe", 8'(port1_oe[0]), 8'(audio_oe[0]));
		// port 0 pin 1 is peripheral-selected, so audio must still take it over
		chk("port0_out", 8'(port0_out[1]), 8'(audio_out[1]));
		chk("port0_oe", 8'(port0_oe[1]), 8'(audio_oe[1]));
		@(posedge clk);
		audio_enable <= 1'b0;
	endtask
	task automatic t_debug;
		wr(8'hf5, 8'h01);
		debug_active <= 1'b1;
		settle();
		chk("port2_oe", 8'(port2_oe), 8'({gpio2_oe[4:3], debug_oe, periph2_oe[0]}));
		chk("port2_out", 8'(port2_out), 8'({gpio2_out[4:3], debug_out, periph2_out[0]}));
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_port0();
		t_priority();
		t_audio();
		t_debug();
		final_report();
	end
endmodule

`default_nettype wire
